/* rtl/ecb_pkg.sv */
// Package with constants and types shared by the event counter bank.
package ecb_pkg;
   localparam int ECB_NARROW_N = 16;
   localparam int ECB_WIDE_N = 64;
   localparam int ECB_NW = 16;
   localparam int ECB_WW = 32;
   localparam int ECB_AW = 8;
   localparam int ECB_IDXW = 6;
   localparam int ECB_NIDXW = 4;

   localparam logic [ECB_AW-1:0] ECB_OFF_PRESET = 8'h00;
   localparam logic [ECB_AW-1:0] ECB_OFF_CMD = 8'h04;
   localparam logic [ECB_AW-1:0] ECB_OFF_DIR_LO = 8'h08;
   localparam logic [ECB_AW-1:0] ECB_OFF_DIR_HI = 8'h0c;
   localparam logic [ECB_AW-1:0] ECB_OFF_SEL = 8'h10;
   localparam logic [ECB_AW-1:0] ECB_OFF_VALUE = 8'h14;
   localparam logic [ECB_AW-1:0] ECB_OFF_STATUS = 8'h18;
   localparam logic [ECB_AW-1:0] ECB_OFF_RUN = 8'h1c;
   localparam logic [ECB_AW-1:0] ECB_ADDR_MASK = 8'hfc;

   localparam int ECB_CMD_WIDE_BIT = 8;
   localparam int ECB_CMD_CLR_BIT = 9;
   localparam int ECB_CMD_EN_BIT = 12;
   localparam int ECB_SEL_WIDE_BIT = 8;
   localparam int ECB_ST_CONTACT_BIT = 0;
   localparam int ECB_ST_COIL_BIT = 1;
   localparam int ECB_ST_LOADED_BIT = 2;
   localparam int ECB_RUN_BIT = 0;

   localparam logic [1:0] ECB_RESP_OKAY = 2'h0;
   localparam logic [1:0] ECB_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [ECB_AW-1:0] awaddr;
      logic awvalid;
      logic [ECB_WW-1:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [ECB_AW-1:0] araddr;
      logic arvalid;
      logic rready;
   } ecb_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [ECB_WW-1:0] rdata;
      logic [1:0] rresp;
   } ecb_axi_rsp_s;
endpackage

/* rtl/ecb_top.sv */
// Event counter bank with narrow stop-at-preset and wide up/down counters.
// Overview of operation
// - Narrow count op energises coil, adds one.
// - Narrow count equal preset drives contact ON.
// - Narrow counter frozen at preset until cleared.
// - Preset loaded at first activation; count rising edges.
// - Clear zeroes count, coil and contact.
// - Sixty-four wide counters enabled by wide op.
// - Per-counter direction flag; OFF counts up.
// - Wide counter holds count when not executed.
// - Wide clear zeroes count and contact.
// - Wide up counter keeps counting past preset.
// - Down count turns contact OFF at preset.
// - Run entry clears wide counters, flags up.
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module ecb_top
   import ecb_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire ecb_axi_req_s axiReq,
   output ecb_axi_rsp_s axiRsp,
   output logic [ECB_NARROW_N-1:0] narrowContact,
   output logic [ECB_NARROW_N-1:0] narrowCoil,
   output logic [ECB_WIDE_N-1:0] wideContact,
   output logic [ECB_WIDE_N-1:0] wideCoil
);
   typedef struct packed {
      logic [ECB_NARROW_N-1:0][ECB_NW-1:0] nCount;
      logic [ECB_NARROW_N-1:0][ECB_NW-1:0] nPreset;
      logic [ECB_NARROW_N-1:0] nLoaded;
      logic [ECB_NARROW_N-1:0] nPrev;
      logic [ECB_NARROW_N-1:0] nCoil;
      logic [ECB_NARROW_N-1:0] nContact;
      logic [ECB_WIDE_N-1:0][ECB_WW-1:0] wCount;
      logic [ECB_WIDE_N-1:0][ECB_WW-1:0] wPreset;
      logic [ECB_WIDE_N-1:0] wPrev;
      logic [ECB_WIDE_N-1:0] wCoil;
      logic [ECB_WIDE_N-1:0] wContact;
      logic [ECB_WIDE_N-1:0] dir;
      logic [ECB_WW-1:0] preset;
      logic [ECB_SEL_WIDE_BIT:0] sel;
      logic awHeld;
      logic [ECB_AW-1:0] awAddr;
      logic wHeld;
      logic [ECB_WW-1:0] wData;
      logic [3:0] wStrb;
      ecb_axi_rsp_s rsp;
   } ecb_state_s;

   ecb_state_s s_q;
   ecb_state_s s_d;
   logic [1:0] rstSync_q;
   logic rstSyncN;

   // Reset is released through two flops so its removal is clock aligned.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rstSync_q <= 2'h0;
      else
         rstSync_q <= {rstSync_q[0], 1'b1};
   end
   assign rstSyncN = rstSync_q[1];

   function automatic logic [ECB_WW-1:0] mergeStrb(
      input logic [ECB_WW-1:0] old,
      input logic [ECB_WW-1:0] data,
      input logic [3:0] strb
   );
      logic [ECB_WW-1:0] res;
      res = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
            res[b*8 +: 8] = data[b*8 +: 8];
      end
      return res;
   endfunction

   function automatic logic [ECB_WW-1:0] readMux(
      input ecb_state_s s,
      input logic [ECB_AW-1:0] addr
   );
      logic [ECB_WW-1:0] r;
      logic [ECB_IDXW-1:0] i;
      logic [ECB_NIDXW-1:0] ni;
      logic wide;
      r = '0;
      i = s.sel[ECB_IDXW-1:0];
      ni = s.sel[ECB_NIDXW-1:0];
      wide = s.sel[ECB_SEL_WIDE_BIT];
      unique case (addr & ECB_ADDR_MASK)
         ECB_OFF_PRESET: r = s.preset;
         ECB_OFF_DIR_LO: r = s.dir[ECB_WW-1:0];
         ECB_OFF_DIR_HI: r = s.dir[ECB_WIDE_N-1:ECB_WW];
         ECB_OFF_SEL: r = {{(ECB_WW-ECB_SEL_WIDE_BIT-1){1'b0}}, s.sel};
         ECB_OFF_VALUE:
         begin
            if (wide)
               r = s.wCount[i];
            else
               r = {{(ECB_WW-ECB_NW){1'b0}}, s.nCount[ni]};
         end
         ECB_OFF_STATUS:
         begin
            if (wide)
            begin
               r[ECB_ST_CONTACT_BIT] = s.wContact[i];
               r[ECB_ST_COIL_BIT] = s.wCoil[i];
               r[ECB_ST_LOADED_BIT] = 1'b1;
            end
            else
            begin
               r[ECB_ST_CONTACT_BIT] = s.nContact[ni];
               r[ECB_ST_COIL_BIT] = s.nCoil[ni];
               r[ECB_ST_LOADED_BIT] = s.nLoaded[ni];
            end
         end
         default: r = '0;
      endcase
      return r;
   endfunction

   // Each command write executes one operation on one counter in one scan; a run write with bit 0 set clears all wide counters.
   function automatic logic isMapped(input logic [ECB_AW-1:0] addr);
      logic [ECB_AW-1:0] a;
      a = addr & ECB_ADDR_MASK;
      return (a == ECB_OFF_PRESET) || (a == ECB_OFF_CMD) ||
         (a == ECB_OFF_DIR_LO) || (a == ECB_OFF_DIR_HI) ||
         (a == ECB_OFF_SEL) || (a == ECB_OFF_VALUE) ||
         (a == ECB_OFF_STATUS) || (a == ECB_OFF_RUN);
   endfunction

   always_comb
   begin
      logic [ECB_IDXW-1:0] idx;
      logic [ECB_NIDXW-1:0] nIdx;
      logic en;
      logic rise;
      logic [ECB_NW-1:0] nPre;
      logic [ECB_WW-1:0] wNext;
      logic [ECB_AW-1:0] wa;
      idx = '0;
      nIdx = '0;
      en = 1'b0;
      rise = 1'b0;
      nPre = '0;
      wNext = '0;
      wa = s_q.awAddr & ECB_ADDR_MASK;
      s_d = s_q;

      if (axiReq.awvalid && s_q.rsp.awready)
      begin
         s_d.awHeld = 1'b1;
         s_d.awAddr = axiReq.awaddr;
      end
      if (axiReq.wvalid && s_q.rsp.wready)
      begin
         s_d.wHeld = 1'b1;
         s_d.wData = axiReq.wdata;
         s_d.wStrb = axiReq.wstrb;
      end
      if (s_q.rsp.bvalid && axiReq.bready)
         s_d.rsp.bvalid = 1'b0;

      if (s_q.awHeld && s_q.wHeld && !s_q.rsp.bvalid)
      begin
         s_d.awHeld = 1'b0;
         s_d.wHeld = 1'b0;
         s_d.rsp.bvalid = 1'b1;
         s_d.rsp.bresp = isMapped(s_q.awAddr) ? ECB_RESP_OKAY :
            ECB_RESP_SLVERR;
         idx = s_q.wData[ECB_IDXW-1:0];
         nIdx = s_q.wData[ECB_NIDXW-1:0];
         en = s_q.wData[ECB_CMD_EN_BIT];
         unique case (wa)
            ECB_OFF_PRESET:
               s_d.preset = mergeStrb(s_q.preset, s_q.wData, s_q.wStrb);
            ECB_OFF_DIR_LO:
               s_d.dir[ECB_WW-1:0] =
                  mergeStrb(s_q.dir[ECB_WW-1:0], s_q.wData, s_q.wStrb);
            ECB_OFF_DIR_HI:
               s_d.dir[ECB_WIDE_N-1:ECB_WW] = mergeStrb(
                  s_q.dir[ECB_WIDE_N-1:ECB_WW], s_q.wData, s_q.wStrb);
            ECB_OFF_SEL:
               s_d.sel = s_q.wData[ECB_SEL_WIDE_BIT:0];
            ECB_OFF_RUN:
            begin
               if (s_q.wData[ECB_RUN_BIT])
               begin
                  s_d.wCount = '0;
                  s_d.wContact = '0;
                  s_d.wCoil = '0;
                  s_d.wPrev = '0;
                  s_d.dir = '0;
               end
            end
            ECB_OFF_CMD:
            begin
               if (s_q.wData[ECB_CMD_WIDE_BIT])
               begin
                  // Only the addressed counter moves; the rest hold.
                  if (s_q.wData[ECB_CMD_CLR_BIT])
                  begin
                     s_d.wCount[idx] = '0;
                     s_d.wContact[idx] = 1'b0;
                     s_d.wCoil[idx] = 1'b0;
                     s_d.wPrev[idx] = 1'b0;
                  end
                  else
                  begin
                     rise = en && !s_q.wPrev[idx];
                     s_d.wPrev[idx] = en;
                     s_d.wCoil[idx] = en;
                     s_d.wPreset[idx] = s_q.preset;
                     // Plain modular arithmetic gives the wrap for free.
                     if (s_q.dir[idx])
                        wNext = s_q.wCount[idx] - 1'b1;
                     else
                        wNext = s_q.wCount[idx] + 1'b1;
                     if (rise)
                     begin
                        s_d.wCount[idx] = wNext;
                        if (wNext == s_q.preset)
                           s_d.wContact[idx] = !s_q.dir[idx];
                     end
                  end
               end
               else if (idx < ECB_IDXW'(ECB_NARROW_N))
               begin
                  // Narrow indices beyond the bank are answered and ignored.
                  if (s_q.wData[ECB_CMD_CLR_BIT])
                  begin
                     s_d.nCount[nIdx] = '0;
                     s_d.nCoil[nIdx] = 1'b0;
                     s_d.nContact[nIdx] = 1'b0;
                     s_d.nLoaded[nIdx] = 1'b0;
                     s_d.nPrev[nIdx] = 1'b0;
                  end
                  else
                  begin
                     rise = en && !s_q.nPrev[nIdx];
                     s_d.nPrev[nIdx] = en;
                     s_d.nCoil[nIdx] = en;
                     // The preset is latched once, so a later preset write
                     // cannot move the goal of a counter already running.
                     nPre = s_q.nLoaded[nIdx] ? s_q.nPreset[nIdx] :
                        s_q.preset[ECB_NW-1:0];
                     if (en && !s_q.nLoaded[nIdx])
                     begin
                        s_d.nLoaded[nIdx] = 1'b1;
                        s_d.nPreset[nIdx] = nPre;
                     end
                     // Reaching preset never clears itself.
                     if (rise && !s_q.nContact[nIdx])
                     begin
                        s_d.nCount[nIdx] = s_q.nCount[nIdx] + 1'b1;
                        s_d.nContact[nIdx] =
                           (s_q.nCount[nIdx] + 1'b1) == nPre;
                     end
                  end
               end
            end
            default: ;
         endcase
      end

      if (s_q.rsp.rvalid && axiReq.rready)
         s_d.rsp.rvalid = 1'b0;
      // Read data come from the state before this edge's write lands.
      if (axiReq.arvalid && s_q.rsp.arready)
      begin
         s_d.rsp.rvalid = 1'b1;
         s_d.rsp.rdata = readMux(s_q, axiReq.araddr);
         s_d.rsp.rresp = isMapped(axiReq.araddr) ? ECB_RESP_OKAY :
            ECB_RESP_SLVERR;
      end

      // One outstanding write and one read; ready drops while held.
      s_d.rsp.awready = !s_d.awHeld;
      s_d.rsp.wready = !s_d.wHeld;
      s_d.rsp.arready = !s_d.rsp.rvalid;
   end

   // Reset starts the wide counters cleared and counting up.
   always_ff @(posedge clk or negedge rstSyncN)
   begin
      if (!rstSyncN)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign axiRsp = s_q.rsp;
   assign narrowContact = s_q.nContact;
   assign narrowCoil = s_q.nCoil;
   assign wideContact = s_q.wContact;
   assign wideCoil = s_q.wCoil;
endmodule

/* tb/ecb_top_asserts.sv */
// Port assertions for the event counter bank.
`timescale 1ns/1ns
module ecb_top_asserts
   import ecb_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire ecb_axi_req_s axiReq,
   input wire ecb_axi_rsp_s axiRsp,
   input wire logic [ECB_NARROW_N-1:0] narrowContact,
   input wire logic [ECB_NARROW_N-1:0] narrowCoil,
   input wire logic [ECB_WIDE_N-1:0] wideContact,
   input wire logic [ECB_WIDE_N-1:0] wideCoil
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   a_bresp_done: assert property (axiRsp.bvalid && axiReq.bready
      |=> !axiRsp.bvalid) else $error("bvalid stuck");
   a_rresp_done: assert property (axiRsp.rvalid && axiReq.rready
      |=> !axiRsp.rvalid) else $error("rvalid stuck");
   a_ar_blocked: assert property (axiRsp.rvalid |-> !axiRsp.arready)
      else $error("arready during read answer");
   a_read_lat: assert property (axiReq.arvalid && axiRsp.arready
      |=> axiRsp.rvalid) else $error("read answer late");
   a_write_lat: assert property (axiReq.awvalid && axiRsp.awready
      && axiReq.wvalid && axiRsp.wready && !axiRsp.bvalid
      |-> ##1 !axiRsp.bvalid ##1 axiRsp.bvalid)
      else $error("write answer timing");
   a_aw_busy: assert property (axiReq.awvalid && axiRsp.awready
      |=> !axiRsp.awready) else $error("awready while busy");
   // A counter may only move with the write that executes its operation.
   a_coil_cause: assert property ($changed({narrowCoil, wideCoil})
      |-> $rose(axiRsp.bvalid)) else $error("coil moved alone");
   a_contact_cause: assert property ($changed({narrowContact,
      wideContact}) |-> $rose(axiRsp.bvalid))
      else $error("contact moved alone");
   a_contact_coil: assert property (!(|({narrowContact,
      wideContact} & ~$past({narrowContact, wideContact})
      & ~{narrowCoil, wideCoil}))) else $error("contact on, coil off");
endmodule

bind ecb_top ecb_top_asserts ecb_top_asserts_inst (.clk(clk),
   .rst_n(rst_n), .axiReq(axiReq), .axiRsp(axiRsp),
   .narrowContact(narrowContact), .narrowCoil(narrowCoil),
   .wideContact(wideContact), .wideCoil(wideCoil));

/* tb/ecb_scan_master.sv */
// Scan engine model issuing count and clear operations over AXI4-Lite.
`timescale 1ns/1ns
module ecb_scan_master
   import ecb_pkg::*;
(
   input wire logic clk,
   output ecb_axi_req_s axiReq,
   input wire ecb_axi_rsp_s axiRsp
);
   initial axiReq = '0;
   // Answers are taken at the rising edge itself; the slave's outputs come
   // from flops, so this process still sees what that edge samples.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
      logic b;
      @(posedge clk);
      axiReq.awaddr <= a;
      axiReq.awvalid <= 1'b1;
      axiReq.wdata <= d;
      axiReq.wstrb <= 4'hf;
      axiReq.wvalid <= 1'b1;
      axiReq.bready <= 1'b1;
      do
      begin
         @(posedge clk);
         b = axiRsp.bvalid;
         r = axiRsp.bresp;
         if (axiReq.awvalid && axiRsp.awready)
         begin
            axiReq.awvalid <= 1'b0;
            axiReq.awaddr <= ~a;
         end
         if (axiReq.wvalid && axiRsp.wready)
         begin
            axiReq.wvalid <= 1'b0;
            axiReq.wdata <= ~d;
         end
      end while (!b);
      axiReq.bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      logic rv;
      @(posedge clk);
      axiReq.araddr <= a;
      axiReq.arvalid <= 1'b1;
      axiReq.rready <= 1'b1;
      do
      begin
         @(posedge clk);
         rv = axiRsp.rvalid;
         d = axiRsp.rdata;
         r = axiRsp.rresp;
         if (axiReq.arvalid && axiRsp.arready)
         begin
            axiReq.arvalid <= 1'b0;
            axiReq.araddr <= ~a;
         end
      end while (!rv);
      axiReq.rready <= 1'b0;
   endtask
endmodule

/* tb/test_event_counter_bank.sv */
// Self-checking bench for the event counter bank.
`timescale 1ns/1ns
module test_event_counter_bank
   import ecb_pkg::*;
;
   localparam logic [31:0] EN = 32'h1 << ECB_CMD_EN_BIT;
   localparam logic [31:0] WD = 32'h1 << ECB_CMD_WIDE_BIT;
   localparam logic [31:0] CLR = 32'h1 << ECB_CMD_CLR_BIT;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   int num_errors = 0;
   int compares = 0;
   int cyc = 0;
   ecb_axi_req_s axiReq;
   ecb_axi_rsp_s axiRsp;
   logic [ECB_NARROW_N-1:0] nCon, nCoil;
   logic [ECB_WIDE_N-1:0] wCon, wCoil;
   logic [31:0] v;
   logic [1:0] r;
   always #4 clk = ~clk;
   ecb_top ecb_top_inst (.clk(clk), .rst_n(rst_n), .axiReq(axiReq),
      .axiRsp(axiRsp), .narrowContact(nCon), .narrowCoil(nCoil),
      .wideContact(wCon), .wideCoil(wCoil));
   ecb_scan_master ecb_scan_master_inst (.clk(clk), .axiReq(axiReq),
      .axiRsp(axiRsp));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      if (num_errors == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ecb_scan_master_inst.wr(a, d, r);
   endtask
   task automatic rd(input logic [7:0] a);
      ecb_scan_master_inst.rd(a, v, r);
   endtask
   task automatic pulses(input logic [31:0] cmd, input int n);
      repeat (n)
      begin
         wr(ECB_OFF_CMD, cmd | EN);
         wr(ECB_OFF_CMD, cmd);
      end
   endtask
   task automatic value(input logic [31:0] sel);
      wr(ECB_OFF_SEL, sel);
      rd(ECB_OFF_VALUE);
   endtask
   task automatic t_narrow();
      wr(ECB_OFF_PRESET, 32'h0000000a);
      pulses(32'h0, 9);
      value(32'h0);
      check(v, 32'h9);
      check(nCon[0], 1'b0);
      wr(ECB_OFF_CMD, EN);
      check(nCoil[0], 1'b1);
      check(nCon[0], 1'b1);
      pulses(32'h0, 3);
      value(32'h0);
      check(v, 32'ha);
      check(nCon[0], 1'b1);
      wr(ECB_OFF_CMD, CLR);
      value(32'h0);
      check(v, 32'h0);
      check({nCon[0], nCoil[0]}, 2'b00);
   endtask
   task automatic t_wide();
      wr(ECB_OFF_PRESET, 32'h0000000a);
      pulses(WD | 32'h3f, 10);
      check(wCon[63], 1'b1);
      pulses(WD | 32'h3f, 10);
      value(WD | 32'h3f);
      check(v, 32'h14);
      check(wCon[63], 1'b1);
      wr(ECB_OFF_DIR_HI, 32'h80000000);
      pulses(WD | 32'h3f, 10);
      check(wCon[63], 1'b0);
      pulses(WD | 32'h3f, 1);
      repeat (20) @(posedge clk);
      value(WD | 32'h3f);
      check(v, 32'h9);
      wr(ECB_OFF_CMD, WD | CLR | 32'h3f);
      check({30'h0, r}, {30'h0, ECB_RESP_OKAY});
      value(WD | 32'h3f);
      check(v, 32'h0);
      check(wCon[63], 1'b0);
   endtask
   task automatic t_wrap();
      wr(ECB_OFF_PRESET, 32'h0);
      wr(ECB_OFF_DIR_LO, 32'h00000002);
      wr(ECB_OFF_CMD, WD | EN | 32'h1);
      check(wCoil[1], 1'b1);
      wr(ECB_OFF_CMD, WD | 32'h1);
      check(wCoil[1], 1'b0);
      value(WD | 32'h1);
      check(v, 32'hffffffff);
      pulses(WD, 1);
      value(WD);
      check(v, 32'h1);
      wr(ECB_OFF_RUN, 32'h1);
      value(WD | 32'h1);
      check(v, 32'h0);
      rd(ECB_OFF_DIR_LO);
      check(v, 32'h0);
      check({30'h0, r}, {30'h0, ECB_RESP_OKAY});
      wr(8'h40, 32'h1);
      check({30'h0, r}, {30'h0, ECB_RESP_SLVERR});
      rd(8'h40);
      check({30'h0, r}, {30'h0, ECB_RESP_SLVERR});
      check(v, 32'h0);
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_narrow();
      t_wide();
      t_wrap();
      stop_test();
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         stop_test();
      end
   end
endmodule
